// >>> design/sld_oc_qual.sv
// overcurrent qualification filter for one driver channel
`timescale 1ns/1ps

module sld_oc_qual (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic oc_i,
  output logic      trip_o
);

  sld_pkg::sld_qual_t st_r;
  sld_pkg::sld_qual_t st_nxt;

  // ==========================================================================
  // count consecutive high samples; any low sample restarts the window
  always_comb begin
    st_nxt = st_r;
    if (oc_i) begin
      if (st_r.cnt != sld_pkg::SLD_QCNT_MAX) begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end else begin
      st_nxt.cnt = '0;
    end
    // trips only on the full qualification count
    st_nxt.trip = oc_i && (st_r.cnt == sld_pkg::SLD_QCNT_MAX);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= sld_pkg::SLD_QUAL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trip_o = st_r.trip;

endmodule : sld_oc_qual

// >>> design/sld_pkg.sv
// shared constants and carrier types for the serial latched driver control
// Functional notes
// - rising serial clock captures serial data into the first shift stage.
// - each further rising edge moves bits toward the cascade output (last).
// - shift register, latches and drivers are eight channels wide.
// - while strobe is high each latch copies its shift stage.
// - latches stay transparent, following shifts, as long as strobe is high.
// - output gate high turns all drivers off; latches and shifts unchanged.
// - output gate low lets each driver follow its latch.
// - overcurrent latches channel off until a positive output gate pulse.
// - overcurrent shorter than 2 us qualification never trips a channel.
// - over-temperature turns device off; release is automatic, no clear.
// - supply-low lockout keeps the device disabled while active.
package sld_pkg;

  // ==========================================================================
  // sizes and timing
  localparam int unsigned SLD_CHANNELS    = 8;
  localparam int unsigned SLD_CLK_MHZ     = 200;
  localparam int unsigned SLD_OC_QUAL_NS  = 2000;
  // least time: round up to whole cycles
  localparam int unsigned SLD_OC_QUAL_CYC =
    (SLD_OC_QUAL_NS * SLD_CLK_MHZ + 999) / 1000;
  localparam int unsigned SLD_QCNT_W      = 9;
  localparam logic [SLD_QCNT_W-1:0] SLD_QCNT_MAX =
    SLD_QCNT_W'(SLD_OC_QUAL_CYC - 1);

  // ==========================================================================
  // carrier types
  typedef logic [SLD_CHANNELS-1:0] sld_ch_t;

  // all pins that arrive from outside the clock domain
  typedef struct packed {
    logic    sclk;
    logic    sdata;
    logic    strobe;
    logic    out_gate;
    logic    over_temp;
    logic    supply_low_lockout;
    sld_ch_t overcurrent;
  } sld_pin_t;

  typedef struct packed {
    sld_pin_t sync1;
    sld_pin_t sync2;
    logic     sclk_prev;
    sld_ch_t  shift;
    sld_ch_t  latch;
    sld_ch_t  fault;
    sld_ch_t  drive;
    logic     cascade;
  } sld_state_t;

  typedef struct packed {
    logic [SLD_QCNT_W-1:0] cnt;
    logic                  trip;
  } sld_qual_t;

  // ==========================================================================
  // reset values
  localparam sld_ch_t    SLD_CH_RST    = 8'h00;
  localparam sld_state_t SLD_STATE_RST = '0;
  localparam sld_qual_t  SLD_QUAL_RST  = '0;

endpackage : sld_pkg

// >>> design/sld_top.sv
// serial shift, strobe latch, output gate and protection logic
`timescale 1ns/1ps

module sld_top (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire sld_pkg::sld_pin_t pins_i,
  output sld_pkg::sld_ch_t       drive_o,
  output logic                   cascade_o
);

  sld_pkg::sld_state_t st_r;
  sld_pkg::sld_state_t st_nxt;
  sld_pkg::sld_ch_t    trip;
  logic                sclk_rise;
  logic                drv_kill;

  // ==========================================================================
  // overcurrent qualification, one filter per channel
  // filters read only the second synchroniser stage
  for (genvar i = 0; i < sld_pkg::SLD_CHANNELS; i++) begin : g_qual
    sld_oc_qual u_qual (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .oc_i   (st_r.sync2.overcurrent[i]),
      .trip_o (trip[i])
    );
  end

  // ==========================================================================
  // edge of the serial clock, taken after both synchroniser stages
  // data and clock share the same delay, so host setup time is kept
  assign sclk_rise = st_r.sync2.sclk & ~st_r.sclk_prev;

  // any of these forces every driver off
  assign drv_kill  = st_r.sync2.out_gate | st_r.sync2.over_temp |
                     st_r.sync2.supply_low_lockout;

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt           = st_r;
    // two-stage synchroniser for every pin
    st_nxt.sync1     = pins_i;
    st_nxt.sync2     = st_r.sync1;
    st_nxt.sclk_prev = st_r.sync2.sclk;

    // eight-stage shift, lsb is the first stage
    if (sclk_rise) begin
      st_nxt.shift = {st_r.shift[sld_pkg::SLD_CHANNELS-2:0],
                      st_r.sync2.sdata};
    end

    // transparent latch: follows the shift stages while strobe is high,
    // including the edge that shifts in the same cycle
    if (st_r.sync2.strobe) begin
      st_nxt.latch = st_nxt.shift;
    end

    // fault flags: a qualified trip wins over a clear pulse in the
    // same cycle, so no event is lost while the gate is high
    st_nxt.fault = (st_r.fault & ~{sld_pkg::SLD_CHANNELS{
                     st_r.sync2.out_gate}}) | trip;
    // lockout acts like a supply cycle and forgets faults
    if (st_r.sync2.supply_low_lockout) begin
      st_nxt.fault = sld_pkg::SLD_CH_RST;
    end

    // drivers: gate, thermal and lockout switch all off; thermal is
    // not latched so drivers come back when the level drops
    if (drv_kill) begin
      st_nxt.drive = sld_pkg::SLD_CH_RST;
    end else begin
      st_nxt.drive = st_nxt.latch & ~st_nxt.fault;
    end

    // cascade output shows the last stage
    st_nxt.cascade = st_nxt.shift[sld_pkg::SLD_CHANNELS-1];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= sld_pkg::SLD_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive_o   = st_r.drive;
  assign cascade_o = st_r.cascade;

  // ==========================================================================
  // helper: consecutive high samples of channel 0 overcurrent, saturating
  // counted apart from the filter, so a short filter count cannot hide
  logic [9:0] oc0_run_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc0_run_r <= '0;
    end else if (!st_r.sync2.overcurrent[0]) begin
      oc0_run_r <= '0;
    end else if (oc0_run_r != 10'h3ff) begin
      oc0_run_r <= oc0_run_r + 1'b1;
    end
  end

  // ==========================================================================
  // assertions
  // attempts that overlap a reset are dropped by the disable
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_capture;
    sclk_rise |=> st_r.shift[0] == $past(st_r.sync2.sdata);
  endproperty
  a_capture: assert property (p_capture)
    else $error("first stage did not capture serial data");

  property p_shift;
    sclk_rise |=> st_r.shift[7:1] == $past(st_r.shift[6:0]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift stages did not advance");

  property p_shift_idle;
    !sclk_rise |=> $stable(st_r.shift);
  endproperty
  a_shift_idle: assert property (p_shift_idle)
    else $error("shift register moved without a clock edge");

  property p_cascade_idle;
    !sclk_rise |=> $stable(cascade_o);
  endproperty
  a_cascade_idle: assert property (p_cascade_idle)
    else $error("cascade output moved without a clock edge");

  property p_cascade;
    sclk_rise |=> ##1 cascade_o == $past(st_r.shift[6], 2);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade output does not show the last stage");

  property p_transparent;
    st_r.sync2.strobe |=> st_r.latch == st_r.shift;
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("latch not following shift while strobe high");

  // a quiet strobe cycle copies the present shift stages
  property p_load;
    st_r.sync2.strobe && !sclk_rise |=> st_r.latch == $past(st_r.shift);
  endproperty
  a_load: assert property (p_load)
    else $error("latch did not load the shift stages");

  property p_hold;
    !st_r.sync2.strobe |=> $stable(st_r.latch);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch changed while strobe low");

  property p_gate_off;
    st_r.sync2.out_gate |=> drive_o == 8'h00;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("driver on while output gate high");

  property p_follow;
    !drv_kill |=> drive_o == (st_r.latch & ~st_r.fault);
  endproperty
  a_follow: assert property (p_follow)
    else $error("drivers do not follow latches");

  property p_fault_hold;
    !st_r.sync2.out_gate && !st_r.sync2.supply_low_lockout
      |=> (st_r.fault & $past(st_r.fault)) == $past(st_r.fault);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag lost without a clear pulse");

  property p_trip;
    !st_r.sync2.supply_low_lockout
      |=> (st_r.fault & $past(trip)) == $past(trip);
  endproperty
  a_trip: assert property (p_trip)
    else $error("qualified trip did not set the fault flag");

  property p_clear;
    st_r.sync2.out_gate && trip == 8'h00 |=> st_r.fault == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault flag survived a clear pulse");

  property p_qual;
    $rose(st_r.fault[0])
      |-> $past(oc0_run_r) >= sld_pkg::SLD_OC_QUAL_CYC;
  endproperty
  a_qual: assert property (p_qual)
    else $error("channel tripped before the qualification time");

  property p_thermal;
    st_r.sync2.over_temp |=> drive_o == 8'h00;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("driver on during over-temperature");

  property p_lockout;
    st_r.sync2.supply_low_lockout |=> drive_o == 8'h00 && st_r.fault == 8'h00;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("device active during supply-low lockout");

  // ==========================================================================
  // covers for the main scenarios
  c_shift_strobe: cover property (sclk_rise && st_r.sync2.strobe);
  c_trip:         cover property ($rose(st_r.fault[0]));
  c_clear:        cover property ($fell(st_r.fault[0]));
  c_thermal_end:  cover property ($fell(st_r.sync2.over_temp));
  c_lockout:      cover property ($rose(st_r.sync2.supply_low_lockout));

endmodule : sld_top

// >>> test/sld_host.sv
// host controller model driving serial clock, data, strobe and gate pins
`timescale 1ns/1ps

module sld_host (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      strobe_o,
  output logic      gate_o
);
  // ==========================================================================
  // pin levels at time zero: drivers gated off
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    strobe_o = 1'b0;
    gate_o = 1'b1;
  end

  // ==========================================================================
  // pacing: four clocks per phase so the two-flop sync never misses one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // strobe and gate levels change together, then settle
  task automatic set(input logic s, input logic g);
    strobe_o = s;
    gate_o = g;
    tick(4);
  endtask : set

  // oldest bit first, so it ends in the last stage
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sdata_o = v[i];
      tick(4);
      sclk_o = 1'b1;
      tick(4);
      sclk_o = 1'b0;
    end
    sdata_o = ~v[0];  // line no longer meaningful after frame
    tick(4);
  endtask : send
endmodule : sld_host

// >>> test/tb.sv
// self-checking bench for the serial latched driver control
`timescale 1ns/1ps

module tb;
  logic              clk_i;
  logic              nrst_i;
  logic              over_temp;
  logic              lockout;
  sld_pkg::sld_ch_t  oc;
  sld_pkg::sld_ch_t  drive_o;
  logic              cascade_o;
  logic              sclk;
  logic              sdata;
  logic              strobe;
  logic              gate;
  sld_pkg::sld_pin_t pins;
  int                errors;
  int                compares;

  // ==========================================================================
  // pin bundle, host pins plus protection levels
  assign pins = '{sclk: sclk, sdata: sdata, strobe: strobe, out_gate: gate,
                  over_temp: over_temp, supply_low_lockout: lockout,
                  overcurrent: oc};

  sld_host h (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
              .strobe_o(strobe), .gate_o(gate));
  sld_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins),
               .drive_o(drive_o), .cascade_o(cascade_o));

  // ==========================================================================
  // compares and closing
  task automatic chk_ch(input string n, input sld_pkg::sld_ch_t e,
                        input sld_pkg::sld_ch_t g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask : chk_ch

  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // ==========================================================================
  // scenarios
  // latches hold while shifting with strobe low, load on a pulse
  task automatic t_shift();
    h.set(1'b0, 1'b0);
    h.send(8'ha5);
    chk_ch("drive held", 8'h00, drive_o);
    chk_bit("cascade", 1'b1, cascade_o);
    h.set(1'b1, 1'b0);
    h.set(1'b0, 1'b0);
    chk_ch("drive load", 8'ha5, drive_o);
    h.send(8'h3c);
    chk_ch("drive held 2", 8'ha5, drive_o);
    chk_bit("cascade 2", 1'b0, cascade_o);
    h.set(1'b1, 1'b0);
    h.set(1'b0, 1'b0);
    chk_ch("drive load 2", 8'h3c, drive_o);
    $display("done t_shift");
  endtask : t_shift

  // transparent latches with gate held high while shifting
  task automatic t_transp();
    h.set(1'b1, 1'b1);
    h.send(8'h81);
    chk_ch("gated off", 8'h00, drive_o);
    h.set(1'b1, 1'b0);
    chk_ch("transparent", 8'h81, drive_o);
    h.set(1'b1, 1'b1);
    h.send(8'h0f);
    h.set(1'b0, 1'b0);
    chk_ch("follow", 8'h0f, drive_o);
    $display("done t_transp");
  endtask : t_transp

  // short overcurrent ignored, long one latches until gate pulse
  task automatic t_oc();
    oc = 8'h01;
    h.tick(300);
    oc = 8'h00;
    h.tick(4);
    chk_ch("short oc", 8'h0f, drive_o);
    oc = 8'h02;
    h.tick(420);
    oc = 8'h00;
    h.tick(20);
    chk_ch("tripped", 8'h0d, drive_o);
    h.set(1'b0, 1'b1);
    h.set(1'b0, 1'b0);
    chk_ch("cleared", 8'h0f, drive_o);
    $display("done t_oc");
  endtask : t_oc

  // thermal and lockout disable, both release without a clear
  task automatic t_prot();
    over_temp = 1'b1;
    h.tick(4);
    chk_ch("hot", 8'h00, drive_o);
    over_temp = 1'b0;
    h.tick(4);
    chk_ch("cool", 8'h0f, drive_o);
    lockout = 1'b1;
    h.tick(4);
    chk_ch("lockout", 8'h00, drive_o);
    lockout = 1'b0;
    h.tick(4);
    chk_ch("release", 8'h0f, drive_o);
    $display("done t_prot");
  endtask : t_prot

  // every channel but channel 1 trips; a clear pulse under overcurrent keeps the fault
  task automatic t_oc_all();
    h.set(1'b1, 1'b1);
    h.send(8'hff);
    h.set(1'b0, 1'b0);
    chk_ch("all on", 8'hff, drive_o);
    oc = 8'hfd;
    h.tick(420);
    chk_ch("trip many", 8'h02, drive_o);
    h.set(1'b0, 1'b1);
    chk_ch("clear gated", 8'h00, drive_o);
    h.set(1'b0, 1'b0);
    chk_ch("trip kept", 8'h02, drive_o);
    oc = 8'h00;
    h.tick(4);
    lockout = 1'b1;
    h.tick(4);
    lockout = 1'b0;
    h.tick(4);
    chk_ch("lockout clear", 8'hff, drive_o);
    $display("done t_oc_all");
  endtask : t_oc_all

  // reset in mid-run empties shift, latch and faults
  task automatic t_rst();
    chk_bit("cascade last", 1'b1, cascade_o);
    nrst_i = 1'b0;
    h.tick(2);
    chk_ch("reset drive", 8'h00, drive_o);
    chk_bit("reset cascade", 1'b0, cascade_o);
    nrst_i = 1'b1;
    h.send(8'h80);
    chk_ch("reset held", 8'h00, drive_o);
    chk_bit("cascade new", 1'b1, cascade_o);
    h.set(1'b1, 1'b0);
    h.set(1'b0, 1'b0);
    chk_ch("reset load", 8'h80, drive_o);
    $display("done t_rst");
  endtask : t_rst

  // ==========================================================================
  // clock, main sequence, watchdog (run is about 1700 clocks)
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    errors = 0;
    compares = 0;
    over_temp = 1'b0;
    lockout = 1'b0;
    oc = 8'h00;
    nrst_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    t_shift();
    t_transp();
    t_oc();
    t_prot();
    t_oc_all();
    t_rst();
    test_done();
  end

  initial begin
    #100us;
    errors++;
    test_done();
  end
endmodule : tb
